// File: spicc_pkg.sv
// Package holding the register map, field layout, reset values and states of the serial clock block.
package spicc_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DIV    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RXDATA = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

	localparam int unsigned BIT_TX_PHASE   = 0;
	localparam int unsigned BIT_RX_PHASE   = 1;
	localparam int unsigned BIT_POLARITY   = 2;
	localparam int unsigned BIT_CLK_SOURCE = 4;

	localparam int unsigned BIT_TX_EMPTY = 0;
	localparam int unsigned BIT_RX_FULL  = 1;
	localparam int unsigned BIT_BUSY     = 2;

	localparam int unsigned PRELOAD_W = 6;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned EDGE_W    = 4;

	localparam logic                 RST_TX_PHASE   = 1'h0;
	localparam logic                 RST_RX_PHASE   = 1'h1;
	localparam logic                 RST_POLARITY   = 1'h0;
	localparam logic                 RST_CLK_SOURCE = 1'h0;
	localparam logic [PRELOAD_W-1:0] RST_PRELOAD    = 6'h02;
	localparam logic [BYTE_W-1:0]    RST_BYTE       = 8'h00;

	localparam logic [PRELOAD_W-1:0] PRELOAD_MAIN = 6'h00;
	localparam logic [EDGE_W-1:0]    LAST_EDGE    = 4'hf;
	localparam logic [EDGE_W-1:0]    FIRST_EDGE   = 4'h0;

	localparam int unsigned NSYNC  = 3;
	localparam int unsigned IN_2M  = 0;
	localparam int unsigned IN_48M = 1;
	localparam int unsigned IN_SDI = 2;

	typedef enum logic [1:0] {
		SPICC_IDLE = 2'b00,
		SPICC_RUN  = 2'b01,
		SPICC_DONE = 2'b10
	} spicc_state_t;

endpackage : spicc_pkg

// File: spicc_core.sv
// Byte-oriented serial master with selectable clock source, polarity and phases behind an APB slave.
//
// Behaviour
// [R01] Clock source bit picks 2 MHz or 48 MHz.
// [R02] Zero preload forces main system clock source.
// [R03] Polarity bit sets idle clock level.
// [R04] Receive phase one samples on even edges.
// [R05] Receive phase zero samples on odd edges.
// [R06] Transmit phase one drives on odd edges.
// [R07] Transmit phase zero presents data before edges.
// [R08] Slave samples on the matching edge parity.
// [R09] Edge choices depend only on phase bits.
// [R10] Software keeps clock settings stable during transfers.
// [R11] Six-bit preload field, resets to two.
// [R12] Transmit write with buffer empty starts transfer.
// [R13] Divider counter reloaded from preload toggles clock.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns

module spicc_core (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [spicc_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [spicc_pkg::DATA_W-1:0]   pwdata,
	output logic      [spicc_pkg::DATA_W-1:0]   prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic                           clk_2mhz_in,
	input  wire logic                           ring_osc_48m_in,
	input  wire logic                           serial_data_in,
	output logic                                sclk_out,
	output logic                                serial_data_out,
	output logic                                select_n_out
);
	import spicc_pkg::*;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	// Configuration registers.
	logic                 transmit_phase_ff;
	logic                 receive_phase_ff;
	logic                 clock_idle_polarity_ff;
	logic                 clock_source_select_ff;
	logic [PRELOAD_W-1:0] preload_ff;

	// Data path state.
	spicc_state_t         state_ff;
	spicc_state_t         nxt_state;
	logic [BYTE_W-1:0]    hold_ff;
	logic                 transmit_buffer_empty_ff;
	logic [BYTE_W-1:0]    tx_sh_ff;
	logic [BYTE_W-1:0]    rx_sh_ff;
	logic [BYTE_W-1:0]    rx_data_ff;
	logic                 rx_full_ff;
	logic                 rx_pend_ff;
	logic [PRELOAD_W-1:0] div_cnt_ff;
	logic [EDGE_W-1:0]    edge_cnt_ff;
	logic                 sclk_ff;
	logic                 sdo_ff;
	logic                 select_n_ff;

	// APB answer registers.
	logic [DATA_W-1:0]    prdata_ff;
	logic                 pslverr_ff;

	// Input synchronisers: two flip-flops, then a third stage used for edge detection.
	logic [NSYNC-1:0]     in_raw;
	logic [NSYNC-1:0]     meta_ff;
	logic [NSYNC-1:0]     sync_ff;
	logic [NSYNC-1:0]     prev_ff;

	assign in_raw[IN_2M]  = clk_2mhz_in;
	assign in_raw[IN_48M] = ring_osc_48m_in;
	assign in_raw[IN_SDI] = serial_data_in;

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_ff[gi] <= 1'b0;
					sync_ff[gi] <= 1'b0;
					prev_ff[gi] <= 1'b0;
				end else begin
					meta_ff[gi] <= in_raw[gi];
					sync_ff[gi] <= meta_ff[gi];
					prev_ff[gi] <= sync_ff[gi];
				end
			end
		end
	endgenerate

	// Bus decode.
	wire setup_phase = psel & ~penable;
	wire access_wr   = psel & penable & pwrite;
	wire access_rd   = psel & penable & ~pwrite;
	wire hit_ctrl    = reg_hit(paddr, OFS_CTRL);
	wire hit_div     = reg_hit(paddr, OFS_DIV);
	wire hit_tx      = reg_hit(paddr, OFS_TXDATA);
	wire hit_rx      = reg_hit(paddr, OFS_RXDATA);
	wire hit_status  = reg_hit(paddr, OFS_STATUS);
	wire hit_any     = hit_ctrl | hit_div | hit_tx | hit_rx | hit_status;
	wire wr_ctrl     = access_wr & hit_ctrl;
	wire wr_div      = access_wr & hit_div;
	wire wr_tx       = access_wr & hit_tx;
	wire rd_rx       = access_rd & hit_rx;

	// Source ticks for the divider.
	wire rise_2m   = sync_ff[IN_2M] & ~prev_ff[IN_2M];
	wire rise_48m  = sync_ff[IN_48M] & ~prev_ff[IN_48M];
	wire use_main  = (preload_ff == PRELOAD_MAIN);                          // see [R02]
	wire ext_tick  = clock_source_select_ff ? rise_2m : rise_48m;           // see [R01]
	wire src_tick  = use_main ? 1'b1 : ext_tick;                            // see [R02]

	wire running   = (state_ff == SPICC_RUN);
	wire div_done  = (div_cnt_ff == PRELOAD_MAIN);
	wire edge_evt  = running & src_tick & div_done;                         // see [R13]
	wire edge_odd  = ~edge_cnt_ff[0];
	wire last_edge = (edge_cnt_ff == LAST_EDGE);

	// Edge choices depend only on the phase bits, never on the idle polarity.
	wire sample_evt = edge_evt & (receive_phase_ff ? ~edge_odd : edge_odd); // see [R04] [R05] [R09]
	wire drive_evt  = edge_evt & ~last_edge
	                & (transmit_phase_ff ? edge_odd : ~edge_odd);            // see [R06] [R07] [R08] [R09]
	wire [BYTE_W-1:0] rx_shifted = {rx_sh_ff[BYTE_W-2:0], sync_ff[IN_SDI]};

	// A byte is pending whenever the holding register is not empty.
	wire start_xfer = (state_ff != SPICC_RUN) & ~transmit_buffer_empty_ff;  // see [R12]

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SPICC_IDLE: begin
				if (start_xfer) begin
					nxt_state = SPICC_RUN;
				end
			end
			SPICC_RUN: begin
				if (edge_evt && last_edge) begin
					nxt_state = SPICC_DONE;
				end
			end
			SPICC_DONE: begin
				nxt_state = start_xfer ? SPICC_RUN : SPICC_IDLE;
			end
			default: begin
				nxt_state = SPICC_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_phase_ff      <= RST_TX_PHASE;
			receive_phase_ff       <= RST_RX_PHASE;
			clock_idle_polarity_ff <= RST_POLARITY;
			clock_source_select_ff <= RST_CLK_SOURCE;
			preload_ff             <= RST_PRELOAD;                          // see [R11]
		end else begin
			if (wr_ctrl) begin
				transmit_phase_ff      <= pwdata[BIT_TX_PHASE];
				receive_phase_ff       <= pwdata[BIT_RX_PHASE];
				clock_idle_polarity_ff <= pwdata[BIT_POLARITY];
				clock_source_select_ff <= pwdata[BIT_CLK_SOURCE];
			end
			if (wr_div) begin
				preload_ff <= pwdata[PRELOAD_W-1:0];                        // see [R11]
			end
		end
	end

	// Holding register and empty flag; the hardware set wins over a same-cycle write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_ff                  <= RST_BYTE;
			transmit_buffer_empty_ff <= 1'b1;
		end else begin
			if (wr_tx) begin
				hold_ff <= pwdata[BYTE_W-1:0];                              // see [R12]
			end
			if (start_xfer) begin
				transmit_buffer_empty_ff <= 1'b1;
			end else if (wr_tx) begin
				transmit_buffer_empty_ff <= 1'b0;                           // see [R12]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= SPICC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Divider and clock pin.  Outside a transfer the clock rests at the idle level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_ff  <= RST_PRELOAD;
			edge_cnt_ff <= FIRST_EDGE;
			sclk_ff     <= RST_POLARITY;
		end else if (!running) begin
			div_cnt_ff  <= preload_ff;
			edge_cnt_ff <= FIRST_EDGE;
			sclk_ff     <= clock_idle_polarity_ff;                          // see [R03]
		end else if (src_tick) begin
			if (div_done) begin
				div_cnt_ff  <= preload_ff;                                  // see [R13]
				edge_cnt_ff <= edge_cnt_ff + 4'h1;
				sclk_ff     <= ~sclk_ff;                                    // see [R03] [R13]
			end else begin
				div_cnt_ff <= div_cnt_ff - 6'h01;
			end
		end
	end

	// Transmit shifter.  With transmit phase zero the first bit is placed at load time.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sh_ff    <= RST_BYTE;
			sdo_ff      <= 1'b0;
			select_n_ff <= 1'b1;
		end else begin
			if (start_xfer) begin
				select_n_ff <= 1'b0;
				if (transmit_phase_ff) begin
					tx_sh_ff <= hold_ff;                                    // see [R06]
				end else begin
					tx_sh_ff <= {hold_ff[BYTE_W-2:0], 1'b0};
					sdo_ff   <= hold_ff[BYTE_W-1];                          // see [R07]
				end
			end else if (drive_evt) begin
				sdo_ff   <= tx_sh_ff[BYTE_W-1];                             // see [R06] [R07]
				tx_sh_ff <= {tx_sh_ff[BYTE_W-2:0], 1'b0};
			end else if (state_ff == SPICC_DONE) begin
				select_n_ff <= 1'b1;
			end
		end
	end

	// Receive path.  A finished byte waits in the shifter while the previous one is unread;
	// the next transfer overwrites it, so software must read before writing again.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sh_ff   <= RST_BYTE;
			rx_data_ff <= RST_BYTE;
			rx_full_ff <= 1'b0;
			rx_pend_ff <= 1'b0;
		end else begin
			if (sample_evt) begin
				rx_sh_ff <= rx_shifted;                                     // see [R04] [R05]
			end
			if (state_ff == SPICC_DONE) begin
				if (rx_full_ff && !rd_rx) begin
					rx_pend_ff <= 1'b1;
				end else begin
					rx_data_ff <= rx_sh_ff;
					rx_full_ff <= 1'b1;
				end
			end else if (rd_rx) begin
				if (rx_pend_ff) begin
					rx_data_ff <= rx_sh_ff;
					rx_pend_ff <= 1'b0;
				end else begin
					rx_full_ff <= 1'b0;
				end
			end
		end
	end

	// Read data is captured in the setup cycle so the access phase never waits.
	wire [DATA_W-1:0] ctrl_word = {27'h0000000, clock_source_select_ff, 1'b0,
	                               clock_idle_polarity_ff, receive_phase_ff, transmit_phase_ff};
	wire [DATA_W-1:0] div_word  = {26'h0000000, preload_ff};
	wire [DATA_W-1:0] tx_word   = {24'h000000, hold_ff};
	wire [DATA_W-1:0] rx_word   = {24'h000000, rx_data_ff};
	wire [DATA_W-1:0] stat_word = {29'h00000000, running, rx_full_ff, transmit_buffer_empty_ff};
	wire [DATA_W-1:0] rd_mux    = hit_ctrl   ? ctrl_word :
	                              hit_div    ? div_word  :
	                              hit_tx     ? tx_word   :
	                              hit_rx     ? rx_word   :
	                              hit_status ? stat_word : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else if (setup_phase) begin
			prdata_ff  <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_ff <= ~hit_any;
		end
	end

	assign prdata          = prdata_ff;
	assign pslverr         = pslverr_ff & psel & penable;
	assign pready          = 1'b1;
	assign sclk_out        = sclk_ff;
	assign serial_data_out = sdo_ff;
	assign select_n_out    = select_n_ff;

endmodule : spicc_core

// File: spicc_asserts.sv
// Port-level assertions for the serial clock block.
`timescale 1ns/1ns
module spicc_asserts (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [spicc_pkg::ADDR_W-1:0] paddr,
	input wire logic [spicc_pkg::DATA_W-1:0] pwdata,
	input wire logic [spicc_pkg::DATA_W-1:0] prdata,
	input wire logic                         sclk_out,
	input wire logic                         serial_data_out,
	input wire logic                         select_n_out
);
	import spicc_pkg::*;
	logic [4:0] ctrl_ff;
	logic [5:0] pre_ff;
	logic [7:0] hold_ff;
	logic [4:0] edges_ff;
	logic       last_ff;
	wire        rd   = psel && penable && !pwrite;
	wire        wr   = psel && penable && pwrite;
	wire  [4:0] seen = edges_ff + 5'(sclk_out != last_ff);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff  <= 5'h02;
			pre_ff   <= 6'h02;
			hold_ff  <= 8'h00;
			edges_ff <= 5'h00;
			last_ff  <= 1'h0;
		end else begin
			if (wr && paddr == OFS_CTRL) ctrl_ff <= pwdata[4:0] & 5'h17;
			if (wr && paddr == OFS_DIV) pre_ff <= pwdata[5:0];
			if (wr && paddr == OFS_TXDATA) hold_ff <= pwdata[7:0];
			edges_ff <= select_n_out ? 5'h00 : seen;
			last_ff  <= sclk_out;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ctrl_readback:
		assert property (rd && paddr == OFS_CTRL |-> prdata == {27'h0, ctrl_ff}) else $error("control read bad");
	a_div_readback:
		assert property (rd && paddr == OFS_DIV |-> prdata == {26'h0, pre_ff}) else $error("preload read bad");
	a_idle_level:
		assert property (select_n_out && $past(select_n_out) && $stable(ctrl_ff[2]) |-> sclk_out == ctrl_ff[2])
			else $error("idle clock level bad");
	a_fast_toggle:
		assert property (pre_ff == 6'h00 && !select_n_out && sclk_out != last_ff && edges_ff < 5'h0f
			|=> sclk_out != last_ff) else $error("main clock half period bad");
	a_byte_edges:
		assert property ($rose(select_n_out) |-> seen == 5'h10) else $error("edge count per byte bad");
	a_first_bit:
		assert property ($fell(select_n_out) && !ctrl_ff[0] |-> serial_data_out == hold_ff[7])
			else $error("first data bit not ready");
	a_out_parity:
		assert property (!select_n_out && !$past(select_n_out) && pre_ff != 6'h00 && seen != 5'h00
			&& $changed(serial_data_out) |-> seen[0] == ctrl_ff[0]) else $error("data changed on wrong edge");
	a_tx_start:
		assert property (wr && paddr == OFS_TXDATA && select_n_out |-> ##[1:3] !select_n_out)
			else $error("transfer did not start");
endmodule : spicc_asserts
bind spicc_core spicc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .sclk_out(sclk_out),
	.serial_data_out(serial_data_out), .select_n_out(select_n_out));

// File: spicc_slave.sv
// Behavioural serial slave that answers one byte per select and records what it receives.
`timescale 1ns/1ns
module spicc_slave (
	input  wire logic       pclk,
	input  wire logic       sclk_out,
	input  wire logic       serial_data_out,
	input  wire logic       select_n_out,
	input  wire logic       tx_phase,
	input  wire logic       rx_phase,
	input  wire logic [7:0] reply,
	output logic            serial_data_in,
	output logic [7:0]      got
);
	logic       prev, on;
	logic [7:0] sh;
	int         edges;
	initial begin
		serial_data_in = 1'h0;
		got = 8'h00;
	end
	always @(posedge pclk) begin
		if (select_n_out) begin
			// A released line toggles so that a stale bit never passes for data.
			serial_data_in <= ~serial_data_in;
			on = 1'h0;
			edges = 0;
			prev = sclk_out;
			sh = reply;
		end else begin
			if (!on && !rx_phase) begin
				serial_data_in <= sh[7];
				sh = sh << 1;
			end
			on = 1'h1;
			if (sclk_out !== prev) begin
				prev = sclk_out;
				edges++;
				if (edges[0] != tx_phase) got = {got[6:0], serial_data_out};
				if (edges[0] == rx_phase && edges < 16) begin
					serial_data_in <= sh[7];
					sh = sh << 1;
				end
			end
		end
	end
endmodule : spicc_slave

// File: testbench.sv
// Self-checking bench for the serial clock block against a slave model.
`timescale 1ns/1ns
module testbench;
	import spicc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, c2m, c48m, err, sdi, sclk, sdo, sel_n, tph, rph, last;
	logic [7:0]  paddr, reply, lfsr, got;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, first_val;
	int          fail_count, tests_run, nedge;
	logic [7:0]  exp_tx_q[$];
	time         t0, t1;
	spicc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clk_2mhz_in(c2m), .ring_osc_48m_in(c48m), .serial_data_in(sdi), .sclk_out(sclk),
		.serial_data_out(sdo), .select_n_out(sel_n));
	spicc_slave peer (.pclk(pclk), .sclk_out(sclk), .serial_data_out(sdo), .select_n_out(sel_n),
		.tx_phase(tph), .rx_phase(rph), .reply(reply), .serial_data_in(sdi), .got(got));
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		c2m = 0;
		forever #250 c2m <= ~c2m;
	end
	// The sources are updated late in the time step so a coincident clock edge never races them.
	initial begin
		c48m = 0;
		forever begin
			#62 c48m <= 1;
			#63 c48m <= 0;
		end
	end
	always @(posedge pclk) begin
		if (!sel_n && sclk !== last) begin
			if (nedge == 0) first_val = sclk;
			if (nedge == 0) t0 = $time;
			t1 = $time;
			nedge++;
		end
		last = sclk;
	end
	function automatic logic [7:0] step(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : step
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	task automatic xfer(input logic [2:0] mode, input logic src, input logic [5:0] pre);
		logic [7:0] tx;
		int span;
		lfsr = step(lfsr);
		tx = lfsr;
		exp_tx_q.push_back(tx);
		lfsr = step(lfsr);
		reply = lfsr;
		tph = mode[0];
		rph = mode[1];
		apb(1, OFS_CTRL, {27'h0, src, 1'b0, mode});
		apb(1, OFS_DIV, {26'h0, pre});
		nedge = 0;
		apb(1, OFS_TXDATA, {24'h0, tx});
		apb(0, OFS_STATUS, 0);
		chk("status at start", 32'h5, rd);
		apb(0, OFS_TXDATA, 0);
		chk("holding readback", {24'h0, tx}, rd);
		do begin
			apb(0, OFS_STATUS, 0);
		end while (rd[BIT_RX_FULL] !== 1'b1);
		apb(0, OFS_RXDATA, 0);
		if (pre != 0) chk("received byte", {24'h0, reply}, rd);
		chk("sent byte", {24'h0, exp_tx_q.pop_front()}, {24'h0, got});
		chk("edge count", 32'h10, 32'(nedge));
		chk("first edge level", {31'h0, !mode[2]}, {31'h0, first_val});
		chk("idle level", {31'h0, mode[2]}, {31'h0, sclk});
		span = (pre == 0) ? 120 : 15 * (pre + 1) * (src ? 500 : 125);
		chk("clock span", 1, 32'(t1 - t0 > span - 17 && t1 - t0 < span + 17));
		$display("transfer mode %0d source %0d preload %0d done", mode, src, pre);
	endtask : xfer
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	initial begin
		#400000;
		fail_count++;
		conclude();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{fail_count, tests_run, nedge, last, tph, reply} = '0;
		rph = 1;
		lfsr = 8'h13;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, OFS_CTRL, 0);
		chk("control reset", 32'h2, rd);
		apb(0, OFS_DIV, 0);
		chk("preload reset", 32'h2, rd);
		apb(0, OFS_STATUS, 0);
		chk("status reset", 32'h1, rd);
		apb(1, OFS_CTRL, 32'hffffffff);
		apb(1, OFS_DIV, 32'hffffffff);
		apb(0, OFS_CTRL, 0);
		chk("control bits", 32'h17, rd);
		apb(0, OFS_DIV, 0);
		chk("preload bits", 32'h3f, rd);
		apb(0, 8'h14, 0);
		chk("unmapped", 32'h1, {31'h0, err});
		$display("register test done");
		for (int i = 0; i < 8; i++) begin
			lfsr = step(lfsr);
			xfer(3'(i), i[0] ^ i[1], 6'(1 + lfsr % 3));
		end
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, OFS_CTRL, 0);
		chk("control after reset", 32'h2, rd);
		apb(0, OFS_DIV, 0);
		chk("preload after reset", 32'h2, rd);
		$display("second reset test done");
		xfer(3'h5, 1'b1, 6'h00);
		conclude();
	end
endmodule : testbench
